/* rtl/pdpwm_defines.svh */
// constants for the pulse-division pwm block
`ifndef PDPWM_DEFINES_SVH
`define PDPWM_DEFINES_SVH

`define PDPWM_ADDR_W 8
`define PDPWM_OFF_CTRL 8'h00
`define PDPWM_OFF_UPPER 8'h04
`define PDPWM_OFF_LOWER 8'h08
`define PDPWM_OFF_STATUS 8'h0C

`define PDPWM_LOWER_W 8
`define PDPWM_SEL_BIT 0
`define PDPWM_CTRL_RSVD 7'h7F
`define PDPWM_WIDTH_READ 8'hFF
`define PDPWM_RESET_DATA 14'h0000
`define PDPWM_RESET_LOWER 8'h00
`define PDPWM_STAT_PENDING 0
`define PDPWM_STAT_SATURATED 1
`define PDPWM_STAT_LEVEL 2

`define PDPWM_RESP_OKAY 2'h0
`define PDPWM_RESP_SLVERR 2'h2

`endif

/* rtl/pdpwm_pkg.sv */
// types for the pulse-division pwm block
package pdpwm_pkg;

  typedef enum logic {
    PDPWM_DIV2,
    PDPWM_DIV4
  } pdpwm_clk_sel_t;

  typedef enum logic [2:0] {
    PDPWM_REG_CTRL,
    PDPWM_REG_UPPER,
    PDPWM_REG_LOWER,
    PDPWM_REG_STATUS,
    PDPWM_REG_NONE
  } pdpwm_reg_t;

endpackage : pdpwm_pkg

/* rtl/pdpwm_top.sv */
// 14-bit pulse-division pwm generator with an axi4-lite register slave
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "pdpwm_defines.svh"

module pdpwm_top import pdpwm_pkg::*; #(
  parameter int DATA_W = 14,
  parameter int PULSE_LOG2 = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`PDPWM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PDPWM_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic shared_waveform_pin
);

  localparam int SLOT_W = DATA_W - PULSE_LOG2;
  localparam int UPPER_W = DATA_W - `PDPWM_LOWER_W;

  function automatic pdpwm_reg_t decode(input logic [`PDPWM_ADDR_W-1:0] addr);
    logic [`PDPWM_ADDR_W-1:0] word;
    word = {addr[`PDPWM_ADDR_W-1:2], 2'b00};
    case (word)
      `PDPWM_OFF_CTRL: decode = PDPWM_REG_CTRL;
      `PDPWM_OFF_UPPER: decode = PDPWM_REG_UPPER;
      `PDPWM_OFF_LOWER: decode = PDPWM_REG_LOWER;
      `PDPWM_OFF_STATUS: decode = PDPWM_REG_STATUS;
      default: decode = PDPWM_REG_NONE;
    endcase
  endfunction : decode

  function automatic logic [PULSE_LOG2-1:0] bit_reverse(input logic [PULSE_LOG2-1:0] v);
    for (int i = 0; i < PULSE_LOG2; i++) begin
      bit_reverse[i] = v[PULSE_LOG2-1-i];
    end
  endfunction : bit_reverse

  // bus side state
  logic aw_held;
  logic w_held;
  logic [`PDPWM_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  pdpwm_reg_t rd_kind;

  // block state
  pdpwm_clk_sel_t period_sel;
  logic [`PDPWM_LOWER_W-1:0] staged_lower;
  logic [DATA_W-1:0] pending_val;
  logic pending;
  logic [DATA_W-1:0] active;
  logic div_phase;
  logic [DATA_W-1:0] cnt;
  logic [DATA_W:0] hi_acc;

  logic aw_hs;
  logic w_hs;
  logic b_hs;
  logic ar_hs;
  logic r_hs;
  logic wr_go;
  pdpwm_reg_t wr_kind;
  logic byte0_wr;
  logic ctrl_wr;
  logic upper_wr;
  logic lower_wr;
  logic [DATA_W-1:0] commit_val;
  logic [`PDPWM_LOWER_W-1:0] lower_in;

  logic tick;
  logic period_end;
  logic [DATA_W:0] high_units;
  logic saturated;
  logic [SLOT_W-1:0] base;
  logic [PULSE_LOG2-1:0] frac;
  logic [PULSE_LOG2-1:0] slot_idx;
  logic [SLOT_W-1:0] pos;
  logic extra;
  logic next_level;

  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign b_hs = s_axi_bvalid & s_axi_bready;
  assign ar_hs = s_axi_arvalid & s_axi_arready;
  assign r_hs = s_axi_rvalid & s_axi_rready;
  assign wr_go = aw_held & w_held & ~s_axi_bvalid;
  assign wr_kind = decode(aw_addr_q);
  // only byte lane 0 carries register data; wider strobes are tolerated, not required
  assign byte0_wr = wr_go & w_strb_q[0];
  assign ctrl_wr = byte0_wr & (wr_kind == PDPWM_REG_CTRL);
  assign upper_wr = byte0_wr & (wr_kind == PDPWM_REG_UPPER);
  assign lower_wr = byte0_wr & (wr_kind == PDPWM_REG_LOWER);
  assign lower_in = w_data_q[`PDPWM_LOWER_W-1:0];
  assign commit_val = {w_data_q[UPPER_W-1:0], staged_lower};

  // write address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr_q <= '0;
      s_axi_awready <= 1'b0;
    end else if (aw_hs) begin
      aw_held <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      if (wr_go) begin
        aw_held <= 1'b0;
      end
      s_axi_awready <= ~aw_held & ~s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_wready <= 1'b0;
    end else if (w_hs) begin
      w_held <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      if (wr_go) begin
        w_held <= 1'b0;
      end
      s_axi_wready <= ~w_held & ~s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PDPWM_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_kind == PDPWM_REG_NONE) ? `PDPWM_RESP_SLVERR : `PDPWM_RESP_OKAY;
    end else if (b_hs) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control register: only the select bit is storage, bits 7:1 read as ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_sel <= PDPWM_DIV2;
    end else if (ctrl_wr) begin
      period_sel <= pdpwm_clk_sel_t'(w_data_q[`PDPWM_SEL_BIT]);
    end
  end

  // lower byte is staged and never touches the running waveform
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      staged_lower <= `PDPWM_RESET_LOWER;
    end else if (lower_wr) begin
      staged_lower <= lower_in;
    end
  end

  // a new commit wins over the period-end clear of the pending flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending <= 1'b0;
      pending_val <= `PDPWM_RESET_DATA;
    end else if (upper_wr) begin
      pending <= 1'b1;
      pending_val <= commit_val;
    end else if (period_end) begin
      pending <= 1'b0;
    end
  end

  // applied only at the period boundary so no period carries a mixed width
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active <= `PDPWM_RESET_DATA;
    end else if (period_end && pending) begin
      active <= pending_val;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_kind <= PDPWM_REG_NONE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `PDPWM_RESP_OKAY;
    end else if (ar_hs) begin
      rd_kind <= decode(s_axi_araddr);
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `PDPWM_RESP_OKAY;
      s_axi_rdata <= '0;
      case (decode(s_axi_araddr))
        PDPWM_REG_CTRL: s_axi_rdata[7:0] <= {`PDPWM_CTRL_RSVD, period_sel};
        PDPWM_REG_UPPER: s_axi_rdata[7:0] <= `PDPWM_WIDTH_READ;
        PDPWM_REG_LOWER: s_axi_rdata[7:0] <= `PDPWM_WIDTH_READ;
        PDPWM_REG_STATUS: begin
          s_axi_rdata[`PDPWM_STAT_PENDING] <= pending;
          s_axi_rdata[`PDPWM_STAT_SATURATED] <= saturated;
          s_axi_rdata[`PDPWM_STAT_LEVEL] <= shared_waveform_pin;
        end
        default: s_axi_rresp <= `PDPWM_RESP_SLVERR;
      endcase
    end else if (r_hs) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= ~s_axi_rvalid;
    end
  end

  // one tick is half a pwm input clock period: every aclk or every other aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_phase <= 1'b0;
    end else begin
      div_phase <= ~div_phase;
    end
  end

  assign tick = (period_sel == PDPWM_DIV2) | div_phase;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '0;
    end else if (tick) begin
      cnt <= cnt + 1'b1;
    end
  end

  assign period_end = tick & (&cnt);
  assign slot_idx = cnt[DATA_W-1:SLOT_W];
  assign pos = cnt[SLOT_W-1:0];
  assign high_units = {1'b0, active} + (DATA_W+1)'(1 << PULSE_LOG2);
  assign saturated = high_units[DATA_W];
  assign base = high_units[DATA_W-1:PULSE_LOG2];
  assign frac = high_units[PULSE_LOG2-1:0];
  // bit-reversed slot order scatters the extra ticks instead of bunching them
  assign extra = bit_reverse(slot_idx) < frac;
  assign next_level = saturated | ({1'b0, pos} < ({1'b0, base} + {{SLOT_W{1'b0}}, extra}));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shared_waveform_pin <= 1'b0;
    end else begin
      shared_waveform_pin <= next_level;
    end
  end

  // high ticks seen so far in this period, read only by the checks below
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_acc <= '0;
    end else if (period_end) begin
      hi_acc <= '0;
    end else if (tick && next_level) begin
      hi_acc <= hi_acc + 1'b1;
    end
  end

  tick_div2_a: assert property (@(posedge aclk) disable iff (!aresetn)
    period_sel == PDPWM_DIV2 |-> tick)
    else $error("tick missing at aclk/2 rate");

  tick_div4_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (period_sel == PDPWM_DIV4 && tick) ##1 (period_sel == PDPWM_DIV4) |-> !tick)
    else $error("tick too fast at aclk/4 rate");

  ctrl_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && rd_kind == PDPWM_REG_CTRL |-> s_axi_rdata[7:1] == `PDPWM_CTRL_RSVD)
    else $error("reserved control bits not read as ones");

  width_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && (rd_kind == PDPWM_REG_UPPER || rd_kind == PDPWM_REG_LOWER)
    |-> s_axi_rdata[7:0] == `PDPWM_WIDTH_READ)
    else $error("width byte read not all ones");

  commit_value_a: assert property (@(posedge aclk) disable iff (!aresetn)
    upper_wr |=> pending && pending_val == $past(commit_val))
    else $error("upper write did not commit both bytes");

  hold_active_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !period_end |=> active == $past(active))
    else $error("width changed inside a period");

  staging_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lower_wr |=> staged_lower == $past(lower_in) && pending_val == $past(pending_val))
    else $error("lower byte not staged");

  reset_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> active == `PDPWM_RESET_DATA && !pending)
    else $error("width not at reset value");

  pulse_slots_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && (&pos) |=> slot_idx == PULSE_LOG2'($past(slot_idx) + 1'b1))
    else $error("pulse slot did not advance");

  high_time_a: assert property (@(posedge aclk) disable iff (!aresetn)
    period_end && !saturated |-> (hi_acc + {{DATA_W{1'b0}}, next_level}) == high_units)
    else $error("high time per period wrong");

  saturate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    saturated |=> shared_waveform_pin)
    else $error("output not held high at full width");

  spread_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !saturated && ({1'b0, pos} > {1'b0, base}) |=> !shared_waveform_pin)
    else $error("pulse wider than its share");

  commit_c: cover property (@(posedge aclk) disable iff (!aresetn) period_end && pending);
  div4_period_c: cover property (@(posedge aclk) disable iff (!aresetn) period_end && period_sel == PDPWM_DIV4);
  saturated_c: cover property (@(posedge aclk) disable iff (!aresetn) saturated && shared_waveform_pin);
  ctrl_read_c: cover property (@(posedge aclk) disable iff (!aresetn) r_hs && rd_kind == PDPWM_REG_CTRL);

endmodule : pdpwm_top

/* tb/pdpwm_filter_model.sv */
// smoothing-filter stand-in: integrates the pwm pin over a window
`timescale 1ns/1ps
module pdpwm_filter_model (
  input wire logic aclk,
  input wire logic pin,
  input wire logic start,
  input wire logic [31:0] span,
  output logic done,
  output logic [31:0] high_cnt,
  output logic [31:0] edge_cnt,
  output logic [31:0] min_w,
  output logic [31:0] max_w
);
  logic [31:0] left = 32'h0;
  logic [31:0] run;
  logic prev;
  logic in_pulse;
  // only pulses that start inside the window count, so a partial first pulse cannot skew min_w
  always @(posedge aclk) begin
    if (start) begin
      left <= span;
      high_cnt <= 32'h0;
      edge_cnt <= 32'h0;
      min_w <= 32'hFFFFFFFF;
      max_w <= 32'h0;
      run <= 32'h0;
      in_pulse <= 1'b0;
      done <= 1'b0;
      prev <= pin;
    end else if (left != 32'h0) begin
      left <= left - 32'h1;
      prev <= pin;
      if (pin) high_cnt <= high_cnt + 32'h1;
      if (pin && !prev) begin
        edge_cnt <= edge_cnt + 32'h1;
        in_pulse <= 1'b1;
        run <= 32'h1;
      end else if (pin) begin
        run <= run + 32'h1;
      end else if (prev && in_pulse) begin
        if (run < min_w) min_w <= run;
        if (run > max_w) max_w <= run;
      end
      if (left == 32'h1) done <= 1'b1;
    end
  end
endmodule : pdpwm_filter_model

/* tb/test_pulse_division_pwm_14bit.sv */
// self-checking bench for the pulse-division pwm block
`timescale 1ns/1ps
`include "pdpwm_defines.svh"
module test_pulse_division_pwm_14bit;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h0;
  logic [7:0] araddr = 8'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, start = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, pin, done;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, hi, ed, mn, mx;
  logic [31:0] span = 32'h0;
  logic [31:0] seed = 32'h163EA;
  int fails = 0;
  int num_checks = 0;

  always #5 aclk = ~aclk;

  pdpwm_top u_pdpwm_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .shared_waveform_pin(pin));

  pdpwm_filter_model u_pdpwm_filter_model (.aclk(aclk), .pin(pin), .start(start), .span(span),
    .done(done), .high_cnt(hi), .edge_cnt(ed), .min_w(mn), .max_w(mx));

  function logic [31:0] rnd_next();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd_next

  // aclk cycles of high time per period; sel 1 doubles every tick
  function logic [31:0] exp_high(input logic [13:0] d, input logic sel);
    return ({18'h0, d} + 32'h40) << sel;
  endfunction : exp_high

  function logic [31:0] exp_slot(input logic [13:0] d, input logic sel);
    return (({18'h0, d} + 32'h40) >> 6) << sel;
  endfunction : exp_slot

  task tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  task check_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] up, input string what);
    num_checks++;
    if (!(got >= lo && got <= up) || $isunknown(got)) begin
      fails++;
      $display("[ERR] %0t %s: got %h expected %h..%h", $time, what, got, lo, up);
    end
  endtask : check_in

  task timeout(input string what);
    fails++;
    $display("[ERR] %0t no answer in %s", $time, what);
    tally_and_finish();
  endtask : timeout

  task axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    if (n >= 100) timeout("write");
    check_in({30'h0, bresp}, {30'h0, er}, {30'h0, er}, "write response");
  endtask : axi_wr

  task axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    if (n >= 100) timeout("read");
    check_in({30'h0, rresp}, {30'h0, er}, {30'h0, er}, "read response");
    if (er === `PDPWM_RESP_OKAY) check_in(rdata, exp, exp, "read data");
  endtask : axi_rd

  task measure(input logic [31:0] len);
    int n;
    n = 0;
    @(posedge aclk);
    span <= len;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (done !== 1'b1 && n < 40000);
    if (n >= 40000) timeout("measure");
  endtask : measure

  task spread_chk(input logic [13:0] d, input logic sel);
    logic [31:0] lo;
    lo = exp_slot(d, sel);
    check_in(mn, lo, lo + (32'h1 << sel), "shortest pulse");
    check_in(mx, lo, lo + (32'h1 << sel), "longest pulse");
  endtask : spread_chk

  initial begin
    logic [13:0] da;
    logic [31:0] r;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    // the pin mux lives outside this block, so the pin is taken as routed to the pwm
    axi_rd(`PDPWM_OFF_CTRL, 32'hFE, `PDPWM_RESP_OKAY);
    axi_rd(`PDPWM_OFF_UPPER, 32'hFF, `PDPWM_RESP_OKAY);
    axi_rd(`PDPWM_OFF_LOWER, 32'hFF, `PDPWM_RESP_OKAY);
    axi_wr(8'h10, 8'h5A, `PDPWM_RESP_SLVERR);
    axi_rd(8'h10, 32'h0, `PDPWM_RESP_SLVERR);
    r = rnd_next();
    axi_wr(`PDPWM_OFF_CTRL, {r[7:1], 1'b0}, `PDPWM_RESP_OKAY);
    axi_rd(`PDPWM_OFF_CTRL, 32'hFE, `PDPWM_RESP_OKAY);
    measure(32'h4000);
    check_in(hi, exp_high(14'h0, 1'b0), exp_high(14'h0, 1'b0), "reset high time");
    check_in(ed, 32'h40, 32'h40, "pulses per period");
    spread_chk(14'h0, 1'b0);
    // kept below 0x3F80 so no two slots merge into one pulse
    r = rnd_next() % 32'h3F80;
    da = r[13:0];
    r = rnd_next();
    axi_wr(`PDPWM_OFF_LOWER, da[7:0], `PDPWM_RESP_OKAY);
    axi_wr(`PDPWM_OFF_UPPER, {r[1:0], da[13:8]}, `PDPWM_RESP_OKAY);
    axi_wr(`PDPWM_OFF_LOWER, ~da[7:0], `PDPWM_RESP_OKAY);
    axi_rd(`PDPWM_OFF_LOWER, 32'hFF, `PDPWM_RESP_OKAY);
    repeat (16400) @(posedge aclk);
    measure(32'h4000);
    check_in(hi, exp_high(da, 1'b0), exp_high(da, 1'b0), "programmed high time");
    check_in(ed, 32'h40, 32'h40, "pulses per period");
    spread_chk(da, 1'b0);
    axi_wr(`PDPWM_OFF_CTRL, 8'h01, `PDPWM_RESP_OKAY);
    axi_rd(`PDPWM_OFF_CTRL, 32'hFF, `PDPWM_RESP_OKAY);
    repeat (1100) @(posedge aclk);
    measure(32'h1000);
    spread_chk(da, 1'b1);
    r = rnd_next();
    axi_wr(`PDPWM_OFF_CTRL, 8'h00, `PDPWM_RESP_OKAY);
    axi_wr(`PDPWM_OFF_LOWER, {2'b11, r[5:0]}, `PDPWM_RESP_OKAY);
    axi_wr(`PDPWM_OFF_UPPER, {r[7:6], 6'h3F}, `PDPWM_RESP_OKAY);
    repeat (16400) @(posedge aclk);
    measure(32'h4000);
    check_in(hi, 32'h4000, 32'h4000, "saturated high time");
    check_in(ed, 32'h0, 32'h0, "saturated edges");
    axi_rd(`PDPWM_OFF_STATUS, 32'h6, `PDPWM_RESP_OKAY);
    tally_and_finish();
  end
endmodule : test_pulse_division_pwm_14bit
